// ===== adc_sequencing_control.sv
// Contract
// - Source 000 pin only, 001 adds bandgap, 010 adds current sense, 011/100 ground, else 000.
// - Reference 00 external pin, 01 supply, 10 and 11 act as 00.
// - Conversion clock is system clock divided by two to the power of field.
// - Conversion starts on falling edge of start bit after software's low-high-low pulse.
// - Start bit rising resets converter and clears busy without converting.
// - Busy goes to one once conversion starts and stays during conversion.
// - Completion clears busy, sets request flag, interrupts only when enabled.
// - Four sampling clocks then twelve conversion clocks, sixteen in total.
// - Result stored at end, latched half clock later; early restart corrupts it.
// - Converter powered only while enable high; software waits to settle.
// - Analog-selected pin drops digital functions, pull-high and direction.
// - Result is unsigned twelve bit code, full scale FFF.
// - Justify bit selects left or right justified result, unused bits zero.
// - Channel codes 0000-0100 pick four pins or voltage sense, else floating.
`include "adc_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_sequencing_control (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Analog core
  input wire logic [11:0] core_result,
  output logic core_power_en,
  output logic core_reset,
  output logic core_sample,
  output logic core_convert,
  output logic conv_clk_en,
  output adc_seq_pkg::analog_sel_t analog_sel,
  // Port A pins in analog mode
  output logic [7:0] pin_analog_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Terminal count of the conversion clock divider
  function automatic logic [6:0] div_max(input logic [2:0] sel);
    logic [7:0] d;
    d = 8'h01 << sel;
    div_max = 7'(d - 8'h01);
  endfunction : div_max

  // Unused nibble reads as zero either way
  function automatic logic [15:0] justify(input logic [11:0] r, input logic right);
    justify = right ? {4'h0, r} : {r, 4'h0};
  endfunction : justify

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] config_0_q;
  logic [7:0] config_1_q;
  logic [7:0] pin_share_q;
  logic irq_status_q;
  logic irq_mask_q;
  logic master_irq_enable_q;
  logic start_prev_q;
  logic busy_q;
  logic [11:0] result_store_q;
  logic [11:0] result_q;
  logic [6:0] div_cnt_q;
  logic [3:0] phase_cnt_q;
  adc_seq_pkg::seq_state_t state_q;
  adc_seq_pkg::seq_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire setup_done = psel & penable & ~pready;
  wire access_end = psel & penable & pready;
  wire wr_en = access_end & pwrite;
  // Full byte-address compare; aliases would hide software bugs
  wire hit_c0 = paddr == `OFS_CONFIG_0;
  wire hit_c1 = paddr == `OFS_CONFIG_1;
  wire hit_rh = paddr == `OFS_RESULT_HIGH;
  wire hit_rl = paddr == `OFS_RESULT_LOW;
  wire hit_ps = paddr == `OFS_PIN_SHARE;
  wire hit_st = paddr == `OFS_IRQ_STATUS;
  wire hit_mk = paddr == `OFS_IRQ_MASK;
  wire hit_me = paddr == `OFS_IRQ_MASTER;
  wire mapped = hit_c0 | hit_c1 | hit_rh | hit_rl | hit_ps | hit_st | hit_mk | hit_me;

  wire [15:0] result_view = justify(result_q, config_0_q[`C0_JUSTIFY]);
  wire [7:0] config_0_view = {config_0_q[7], busy_q, config_0_q[5:0]};
  // Unmapped reads return zero alongside the error flag
  wire [7:0] rd_byte =
    hit_c0 ? config_0_view :
    hit_c1 ? config_1_q :
    hit_rh ? result_view[15:8] :
    hit_rl ? result_view[7:0] :
    hit_ps ? pin_share_q :
    hit_st ? {7'h00, irq_status_q} :
    hit_mk ? {7'h00, irq_mask_q} :
    hit_me ? {7'h00, master_irq_enable_q} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Control field views

  wire start_bit = config_0_q[`C0_START];
  wire power_en = config_0_q[`C0_POWER];
  wire [3:0] chan_sel = config_0_q[`C0_CHAN_HI:`C0_CHAN_LO];
  wire [2:0] src_sel = config_1_q[`C1_SRC_HI:`C1_SRC_LO];
  wire [1:0] ref_sel = config_1_q[`C1_REF_HI:`C1_REF_LO];
  wire [2:0] div_sel = config_1_q[`C1_DIV_HI:`C1_DIV_LO];

  wire start_rise = start_bit & ~start_prev_q;
  wire start_fall = ~start_bit & start_prev_q;
  // Counters restart on every clear source so each conversion is aligned
  wire seq_clear = start_rise | ~power_en;
  wire [6:0] dmax = div_max(div_sel);
  wire tick = div_cnt_q == dmax;
  // Half conversion clock after the tick that ended the conversion
  wire half_tick = div_cnt_q == (dmax >> 1);
  wire phase_last_sample = phase_cnt_q == 4'(`SAMPLE_CLKS - 4'h1);
  wire phase_last_conv = phase_cnt_q == 4'(`CONVERT_CLKS - 4'h1);
  wire conv_done = (state_q == adc_seq_pkg::ST_CONVERT) & tick & phase_last_conv;
  // Restart inside the latch window leaves a zeroed word visible
  wire latch_abort = start_rise & (state_q == adc_seq_pkg::ST_LATCH);

  ////////////////////////////////////////////////////////////////////////////
  // Source, reference and channel selection

  wire src_internal_gnd = (src_sel == `SRC_GND_A) | (src_sel == `SRC_GND_B);
  // Codes past the last channel leave the input floating
  wire [4:0] chan_onehot = (chan_sel <= `CHAN_LAST) ? 5'(5'h01 << chan_sel) : 5'h00;

  // Internal sources keep the pin connected; ground isolates it
  adc_seq_pkg::analog_sel_t sel_d;
  always_comb begin
    sel_d.ext_channel = chan_onehot;
    sel_d.ext_connect = ~src_internal_gnd;
    sel_d.bandgap = src_sel == `SRC_BANDGAP;
    sel_d.current_sense = src_sel == `SRC_ISENSE;
    sel_d.ground = src_internal_gnd;
    sel_d.ref_ext_pin = ref_sel != `REF_VDD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      adc_seq_pkg::ST_IDLE: begin
        if (start_fall) begin
          state_d = adc_seq_pkg::ST_SAMPLE;
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (tick && phase_last_sample) begin
          state_d = adc_seq_pkg::ST_CONVERT;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (conv_done) begin
          state_d = adc_seq_pkg::ST_LATCH;
        end
      end
      adc_seq_pkg::ST_LATCH: begin
        if (half_tick) begin
          state_d = adc_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = adc_seq_pkg::ST_IDLE;
      end
    endcase
    if (seq_clear) begin
      state_d = adc_seq_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_seq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Free-running while idle; a start fall realigns the first tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 7'h00;
    end else if (seq_clear || start_fall || tick) begin
      div_cnt_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // Phase count restarts at the sample-to-convert boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_q <= 4'h0;
    end else if (seq_clear || start_fall) begin
      phase_cnt_q <= 4'h0;
    end else if (tick && state_q == adc_seq_pkg::ST_SAMPLE && phase_last_sample) begin
      phase_cnt_q <= 4'h0;
    end else if (tick && (state_q == adc_seq_pkg::ST_SAMPLE || state_q == adc_seq_pkg::ST_CONVERT)) begin
      phase_cnt_q <= phase_cnt_q + 4'h1;
    end
  end

  // Abort and completion win over a same-cycle start fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
      if (start_rise || !power_en || conv_done) begin
        busy_q <= 1'b0;
      end else if (start_fall) begin
        busy_q <= 1'b1;
      end
    end
  end

  // An early restart wipes the stored word before the latch lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_store_q <= 12'h000;
      result_q <= 12'h000;
    end else begin
      if (conv_done) begin
        result_store_q <= core_result;
      end else if (latch_abort) begin
        result_store_q <= 12'h000;
      end
      if (latch_abort) begin
        result_q <= 12'h000;
      end else if (state_q == adc_seq_pkg::ST_LATCH && half_tick) begin
        result_q <= result_store_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Busy bit is hardware-owned, so writes to it are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_0_q <= `RST_CONFIG_0;
      config_1_q <= `RST_CONFIG_1;
      pin_share_q <= `RST_PIN_SHARE;
      irq_mask_q <= 1'b0;
      master_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      if (hit_c0) begin
        config_0_q <= {pwdata[7], 1'b0, pwdata[5:0]};
      end
      if (hit_c1) begin
        config_1_q <= pwdata[7:0];
      end
      if (hit_ps) begin
        pin_share_q <= pwdata[7:0];
      end
      if (hit_mk) begin
        irq_mask_q <= pwdata[`IRQ_DONE];
      end
      if (hit_me) begin
        master_irq_enable_q <= pwdata[0];
      end
    end
  end

  // Set beats a same-cycle write-one clear so no completion is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 1'b0;
    end else if (conv_done) begin
      irq_status_q <= 1'b1;
    end else if (wr_en && hit_st && pwdata[`IRQ_DONE]) begin
      irq_status_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state so every bus output is a flop

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_done;
      if (setup_done) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Phase outputs follow the next state, so they line up with state_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      core_power_en <= 1'b0;
      core_reset <= 1'b1;
      core_sample <= 1'b0;
      core_convert <= 1'b0;
      conv_clk_en <= 1'b0;
      analog_sel <= '0;
      pin_analog_mode <= 8'h00;
    end else begin
      // Master enable and mask both gate the level output
      irq <= master_irq_enable_q & irq_mask_q & irq_status_q;
      core_power_en <= power_en;
      // Core held in reset while powered down
      core_reset <= seq_clear;
      core_sample <= state_d == adc_seq_pkg::ST_SAMPLE;
      core_convert <= state_d == adc_seq_pkg::ST_CONVERT;
      conv_clk_en <= tick & power_en;
      analog_sel <= sel_d;
      pin_analog_mode <= pin_share_q;
    end
  end

endmodule : adc_sequencing_control

`default_nettype wire

// ===== adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Register byte offsets
`define OFS_CONFIG_0 8'h00
`define OFS_CONFIG_1 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_PIN_SHARE 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_IRQ_MASTER 8'h1C

// Reset values
`define RST_CONFIG_0 8'h00
`define RST_CONFIG_1 8'h00
`define RST_PIN_SHARE 8'h00

// converter_config_0 fields
`define C0_START 7
`define C0_BUSY 6
`define C0_POWER 5
`define C0_JUSTIFY 4
`define C0_CHAN_HI 3
`define C0_CHAN_LO 0

// converter_config_1 fields
`define C1_SRC_HI 7
`define C1_SRC_LO 5
`define C1_REF_HI 4
`define C1_REF_LO 3
`define C1_DIV_HI 2
`define C1_DIV_LO 0

// Interrupt status/mask bit
`define IRQ_DONE 0

// Field codes
`define SRC_EXT 3'h0
`define SRC_BANDGAP 3'h1
`define SRC_ISENSE 3'h2
`define SRC_GND_A 3'h3
`define SRC_GND_B 3'h4
`define REF_VDD 2'h1
`define CHAN_LAST 4'h4

// Sequence lengths in conversion clocks
`define SAMPLE_CLKS 4'h4
`define CONVERT_CLKS 4'hC

`endif

// ===== adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3,
    ST_LATCH = 2'h2
  } seq_state_t;

  typedef struct packed {
    logic [4:0] ext_channel;
    logic ext_connect;
    logic bandgap;
    logic current_sense;
    logic ground;
    logic ref_ext_pin;
  } analog_sel_t;

endpackage : adc_seq_pkg

// ===== adc_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_sva (
  // Clock and bus answer
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  // Analog core controls
  input wire logic core_power_en,
  input wire logic core_reset,
  input wire logic core_sample,
  input wire logic core_convert,
  input wire logic conv_clk_en,
  input wire adc_seq_pkg::analog_sel_t analog_sel
);
  logic [7:0] ns_q;
  logic [7:0] nc_q;
  logic smp_q;
  logic cnv_q;
  // Tick pulses lag a cycle, so the phases are tracked one cycle late too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ns_q <= 8'h00;
      nc_q <= 8'h00;
      smp_q <= 1'b0;
      cnv_q <= 1'b0;
    end else begin
      smp_q <= core_sample;
      cnv_q <= core_convert;
      ns_q <= smp_q ? ns_q + {7'h00, conv_clk_en} : 8'h00;
      nc_q <= cnv_q ? nc_q + {7'h00, conv_clk_en} : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_gnd;
    analog_sel.ground |-> !(analog_sel.ext_connect || analog_sel.bandgap || analog_sel.current_sense);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground mixed");
  property p_int; !(analog_sel.bandgap && analog_sel.current_sense); endproperty
  a_int: assert property (p_int) else $error("two internal sources");
  property p_chan; $onehot0(analog_sel.ext_channel); endproperty
  a_chan: assert property (p_chan) else $error("channel not one-hot");
  property p_excl; !(core_sample && core_convert); endproperty
  a_excl: assert property (p_excl) else $error("phases overlap");
  property p_slen; $fell(core_sample) && !core_reset |=> ns_q == 8'h04; endproperty
  a_slen: assert property (p_slen) else $error("sample length");
  property p_clen; $fell(core_convert) && !core_reset |=> nc_q == 8'h0C; endproperty
  a_clen: assert property (p_clen) else $error("convert length");
  property p_off; !core_power_en && !$past(core_power_en) |-> core_reset && !core_sample && !core_convert; endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_noclk; !core_power_en && !$past(core_power_en) |-> !conv_clk_en; endproperty
  a_noclk: assert property (p_noclk) else $error("tick while off");
endmodule : adc_seq_sva
bind adc_sequencing_control adc_seq_sva u_sva (.pclk, .presetn, .pready, .pslverr, .core_power_en, .core_reset,
  .core_sample, .core_convert, .conv_clk_en, .analog_sel);
`default_nettype wire

// ===== adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  // Clock and analog level
  input wire logic pclk,
  input wire logic [11:0] level,
  // Controls from the block
  input wire logic core_power_en,
  input wire logic core_convert,
  input wire adc_seq_pkg::analog_sel_t analog_sel,
  // Code back
  output logic [11:0] core_result
);
  logic [11:0] last_q;
  logic [11:0] mix;
  // Each route flips its own bits, so a wrong route shows in the code
  assign mix = level ^ {analog_sel.bandgap, analog_sel.current_sense, 4'h0, analog_sel.ref_ext_pin,
    analog_sel.ext_channel & {5{analog_sel.ext_connect}}};
  // Outside conversion the code is junk, never a held value
  assign core_result = (core_power_en && core_convert) ? (analog_sel.ground ? 12'h000 : mix) : ~last_q;
  always_ff @(posedge pclk) last_q <= core_result;
endmodule : adc_core_model
`default_nettype wire

// ===== adc_sequencing_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequencing_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic core_power_en, core_reset, core_sample, core_convert, conv_clk_en;
  logic [7:0] paddr, pin_analog_mode, pin, cfg;
  logic [31:0] pwdata, prdata;
  logic [11:0] core_result, level, x;
  logic [3:0] ch;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  adc_seq_pkg::analog_sel_t analog_sel;
  int err_count, comparisons, cyc, n;
  adc_sequencing_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .core_result, .core_power_en, .core_reset, .core_sample, .core_convert, .conv_clk_en,
    .analog_sel, .pin_analog_mode);
  adc_core_model model (.pclk, .level, .core_power_en, .core_convert, .analog_sel, .core_result);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    comparisons++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Idle edge first, so psel never gets two values in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic er);
    exp_q.push_back({er, m, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, a, {24'h0, d}, 32'hFFFFFFFF, 1'b0);
  endtask : rd
  function automatic logic [11:0] want_code(input int s, input logic [3:0] c, input logic [11:0] v);
    if (s == 3 || s == 4) return 12'h000;
    return v ^ {s == 1, s == 2, 4'h0, s[1:0] != 2'b01, c < 4'h5 ? 5'h01 << c : 5'h00};
  endfunction : want_code
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end
    if (cyc == 12000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 12'h000;
    void'($urandom(42608));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wr(`OFS_RESULT_HIGH, 8'hFF);
    xfer(1'b1, 8'h24, 32'hFF, 32'h0, 1'b1);
    xfer(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF, 1'b1);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
    $display("test reset done");
    wr(`OFS_IRQ_MASTER, 8'h01);
    wr(`OFS_CONFIG_0, 8'h20);
    repeat (20) @(posedge pclk);
    chk({32'h0, core_power_en}, 33'h1);
    for (int k = 0; k < 8; k++) begin
      x = 12'($urandom);
      level <= x;
      ch = 4'($urandom);
      pin = 8'($urandom);
      if (k[1:0] != 2'b01) pin[2:1] = 2'b10;
      cfg = {2'b00, 1'b1, k[0], ch};
      wr(`OFS_PIN_SHARE, pin);
      wr(`OFS_CONFIG_1, {k[2:0], k[1:0], k[2:0]});
      chk({25'h0, pin_analog_mode}, {25'h0, pin});
      wr(`OFS_IRQ_MASK, {7'h0, k != 5});
      wr(`OFS_CONFIG_0, cfg | 8'h80);
      rd(`OFS_CONFIG_0, cfg | 8'h80);
      wr(`OFS_CONFIG_0, cfg);
      if (k == 2) begin
        wr(`OFS_CONFIG_0, cfg | 8'h80);
        rd(`OFS_CONFIG_0, cfg | 8'h80);
        repeat ((16 << k) + 4) @(posedge pclk);
        rd(`OFS_IRQ_STATUS, 8'h00);
        wr(`OFS_CONFIG_0, cfg);
      end
      rd(`OFS_CONFIG_0, cfg | 8'h40);
      if (k == 5) begin
        repeat ((16 << k) + 8) @(posedge pclk);
        chk({32'h0, irq}, 33'h0);
        wr(`OFS_IRQ_MASK, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h01);
      end else begin
        n = 0;
        while (irq !== 1'b1 && n < (16 << k) + 8) begin
          @(posedge pclk);
          n++;
        end
        chk({32'h0, n > (16 << k) - 12}, 33'h1);
      end
      chk({32'h0, irq}, 33'h1);
      repeat ((1 << k) / 2 + 2) @(posedge pclk);
      x = want_code(k, ch, x);
      rd(`OFS_CONFIG_0, cfg);
      rd(`OFS_RESULT_HIGH, k[0] ? {4'h0, x[11:8]} : x[11:4]);
      rd(`OFS_RESULT_LOW, k[0] ? x[7:0] : {x[3:0], 4'h0});
      wr(`OFS_IRQ_STATUS, 8'h01);
      rd(`OFS_IRQ_STATUS, 8'h00);
      chk({32'h0, irq}, 33'h0);
      $display("test conversion %0d done", k);
    end
    complete_run();
  end
endmodule : adc_sequencing_control_tb
`default_nettype wire
